// [verilog/vib_pins_pkg.sv]
package vib_pins_pkg;

    // Register byte offsets on the APB bus.
    localparam logic [7:0] GLOBAL_COMMAND_OFFSET = 8'h00;
    localparam logic [7:0] MISC_CONTROL_OFFSET = 8'h04;
    localparam logic [7:0] MODE_OFFSET = 8'h08;
    localparam logic [7:0] ALARM_CONTROL_OFFSET = 8'h0C;
    localparam logic [7:0] STATUS_OFFSET = 8'h10;
    localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h14;
    localparam logic [7:0] IRQ_MASK_OFFSET = 8'h18;

    // Command codes written to the global command register.
    localparam logic [15:0] CMD_CAPTURE = 16'h0800;
    localparam logic [15:0] CMD_ESCAPE = 16'h00E8;

    // Field positions.
    localparam int TRIG_ENABLE_BIT = 12;
    localparam int ALARM_ENABLE_LSB = 0;
    localparam int ALARM_POLARITY_LSB = 2;
    localparam int FLASH_MODE_LSB = 0;
    localparam int FLASH_ALARM_LSB = 16;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_ACTIVE_BIT = 1;
    localparam int STATUS_SHUTDOWN_BIT = 2;
    localparam int STATUS_LOADING_BIT = 3;
    localparam int STATUS_MODE_LSB = 4;

    // Interrupt status bits.
    localparam int IRQ_RECORD_DONE = 0;
    localparam int IRQ_TRIGGER = 1;
    localparam int IRQ_OVERTEMP = 2;
    localparam int IRQ_ESCAPE = 3;
    localparam int IRQ_WIDTH = 4;

    // Reset values.
    localparam logic [15:0] MISC_CONTROL_RESET = 16'h0000;
    localparam logic [3:0] ALARM_CONTROL_RESET = 4'h0;
    localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

    // Timing: shortest trigger pulse and the clock period.
    localparam int CLK_PERIOD_NS = 40;
    localparam int TRIG_MIN_PULSE_NS = 50;
    localparam int TRIG_MIN_PULSE_CYCLES = (TRIG_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Record modes.
    typedef enum logic [1:0] {
        MODE_MANUAL_TIME = 2'b00,
        MODE_MANUAL_SPECTRAL = 2'b01,
        MODE_AUTO_SPECTRAL = 2'b10,
        MODE_STREAMING = 2'b11
    } mode_type;

    // Capture engine states.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RECORD = 2'b01,
        ST_READY_GAP = 2'b10
    } state_type;

endpackage : vib_pins_pkg

// [verilog/pin_sync.sv]
`timescale 1ns/1ps
module pin_sync
    import vib_pins_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Pin levels and the filtered copy.
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;

    // Three stages; the first is read only by the second.
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            meta_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end
        else
        begin
            meta_r <= pin_in;
            s2_r <= meta_r;
            s3_r <= s2_r;
        end
    end

    // A level change is taken only once stages two and three agree.
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            always_ff @(posedge clk_in or negedge rst_n_in)
            begin
                if (!rst_n_in)
                    level_out[i] <= 1'b0;
                else if (s2_r[i] == s3_r[i])
                    level_out[i] <= s3_r[i];
            end
        end
    endgenerate

endmodule : pin_sync

// [verilog/settings_reload.sv]
`timescale 1ns/1ps
module settings_reload
    import vib_pins_pkg::*;
#(
    parameter int LOAD_CYCLES = 16
)
(
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Stored settings word and load results.
    input wire logic [31:0] flash_word_in,
    output logic loading_out,
    output logic load_pulse_out,
    output logic [31:0] cfg_out
);

    logic [15:0] cnt_r;

    // The flash read takes LOAD_CYCLES after each reset release; the word is
    // sampled by the clock at the end, never by the reset itself.
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cnt_r <= '0;
            loading_out <= 1'b1;
            load_pulse_out <= 1'b0;
            cfg_out <= '0;
        end
        else
        begin
            load_pulse_out <= 1'b0;
            if (loading_out)
            begin
                if (cnt_r == 16'(LOAD_CYCLES - 1))
                begin
                    loading_out <= 1'b0;
                    load_pulse_out <= 1'b1;
                    cfg_out <= flash_word_in;
                end
                else
                    cnt_r <= cnt_r + 16'h0001;
            end
        end
    end

endmodule : settings_reload

// [verilog/vibration_sensor_host_pins.sv]
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ps
// What this block does
// (RULE_01) Trigger pin edge acts only with enable bit
// (RULE_02) Manual modes: rising trigger starts one record
// (RULE_03) Continuous modes: convert while high, finish record
// (RULE_04) Streaming: busy low loading, high when ready
// (RULE_05) Otherwise refuse access while busy, then release
// (RULE_06) Escape code accepted while busy, aborts capture
// (RULE_07) Alarms per control register, silent in streaming
// (RULE_08) Supply monitor low on overtemperature shutdown
// (RULE_09) Reset pin resets and reloads flash settings
// (RULE_10) Busy low from acceptance until operation completes
module vibration_sensor_host_pins
    import vib_pins_pkg::*;
#(
    parameter int RECORD_CYCLES = 4096,
    parameter int READY_GAP_CYCLES = 64,
    parameter int FLASH_LOAD_CYCLES = 16
)
(
    // Clock and reset.
    input wire logic CLK_SYS_IN,
    input wire logic NRST_IN,
    // APB slave.
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // Host pins.
    input wire logic TRIGGER_IN,
    input wire logic OVERTEMP_IN,
    output logic BUSY_OUT,
    output logic ALARM_OUT_FIRST_OUT,
    output logic ALARM_OUT_SECOND_OUT,
    output logic SUPPLY_MONITOR_OUT,
    // Internal sources.
    input wire logic [1:0] ALARM_EVENT_IN,
    input wire logic [31:0] FLASH_WORD_IN,
    // Interrupt.
    output logic IRQ_OUT
);

    logic rst_meta_r;
    logic rst_n;
    logic trig_level;
    logic overtemp_level;
    logic trig_prev_r;
    logic loading;
    logic load_pulse;
    logic [31:0] flash_cfg;
    logic [15:0] misc_ctrl_r;
    mode_type mode_r;
    logic [3:0] alarm_ctrl_r;
    logic [IRQ_WIDTH-1:0] irq_status_r;
    logic [IRQ_WIDTH-1:0] irq_mask_r;
    logic [IRQ_WIDTH-1:0] irq_set;
    state_type state_r;
    logic [15:0] cnt_r;
    logic shutdown_r;
    logic busy_r;
    logic continuous;
    logic trig_en;
    logic trig_rise;
    logic refuse;
    logic apb_access;
    logic wr_cmd;
    logic cmd_capture;
    logic cmd_escape;
    logic wr_ok;
    logic record_done;
    logic gap_done;

    // Reset pin is released through two flops; assertion is immediate.
    always_ff @(posedge CLK_SYS_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r; // [RULE_09]
        end
    end

    pin_sync #(.WIDTH(2)) u_pin_sync (
        .clk_in(CLK_SYS_IN),
        .rst_n_in(rst_n),
        .pin_in({OVERTEMP_IN, TRIGGER_IN}),
        .level_out({overtemp_level, trig_level})
    );

    settings_reload #(.LOAD_CYCLES(FLASH_LOAD_CYCLES)) u_reload (
        .clk_in(CLK_SYS_IN),
        .rst_n_in(rst_n),
        .flash_word_in(FLASH_WORD_IN),
        .loading_out(loading),
        .load_pulse_out(load_pulse),
        .cfg_out(flash_cfg)
    );

    // Mode decode and trigger qualification.
    assign continuous = (mode_r == MODE_AUTO_SPECTRAL) || (mode_r == MODE_STREAMING);
    assign trig_en = misc_ctrl_r[TRIG_ENABLE_BIT]; // [RULE_01]
    assign trig_rise = trig_en && trig_level && !trig_prev_r; // [RULE_01]

    // Access is refused while loading or busy outside streaming mode.
    assign refuse = loading || (state_r != ST_IDLE && mode_r != MODE_STREAMING); // [RULE_05]
    assign apb_access = PSEL_IN && PENABLE_IN;
    assign wr_cmd = apb_access && PWRITE_IN && PADDR_IN == GLOBAL_COMMAND_OFFSET;
    assign cmd_escape = wr_cmd && PWDATA_IN[15:0] == CMD_ESCAPE; // [RULE_06]
    assign wr_ok = apb_access && PWRITE_IN && !refuse;
    assign cmd_capture = wr_ok && wr_cmd && PWDATA_IN[15:0] == CMD_CAPTURE; // [RULE_02]
    assign record_done = state_r == ST_RECORD && cnt_r == 16'(RECORD_CYCLES - 1);
    assign gap_done = state_r == ST_READY_GAP && cnt_r == 16'(READY_GAP_CYCLES - 1);

    // Zero-wait slave; refused accesses end with an error.
    assign PREADY_OUT = 1'b1;
    assign PSLVERR_OUT = apb_access && refuse && !cmd_escape; // [RULE_05] [RULE_06]

    always_ff @(posedge CLK_SYS_IN or negedge rst_n)
    begin
        if (!rst_n)
            trig_prev_r <= 1'b0;
        else
            trig_prev_r <= trig_level;
    end

    // Configuration registers; mode, alarm control and the trigger enable bit reloaded from flash after every reset.
    always_ff @(posedge CLK_SYS_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            misc_ctrl_r <= MISC_CONTROL_RESET;
            mode_r <= MODE_MANUAL_TIME;
            alarm_ctrl_r <= ALARM_CONTROL_RESET;
            irq_mask_r <= IRQ_MASK_RESET;
        end
        else if (load_pulse)
        begin
            misc_ctrl_r <= MISC_CONTROL_RESET; // [RULE_09]
            misc_ctrl_r[TRIG_ENABLE_BIT] <= flash_cfg[TRIG_ENABLE_BIT];
            mode_r <= mode_type'(flash_cfg[FLASH_MODE_LSB +: 2]);
            alarm_ctrl_r <= flash_cfg[FLASH_ALARM_LSB +: 4];
        end
        else if (wr_ok)
        begin
            unique case (PADDR_IN)
                MISC_CONTROL_OFFSET: misc_ctrl_r <= PWDATA_IN[15:0];
                MODE_OFFSET: mode_r <= mode_type'(PWDATA_IN[1:0]);
                ALARM_CONTROL_OFFSET: alarm_ctrl_r <= PWDATA_IN[3:0];
                IRQ_MASK_OFFSET: irq_mask_r <= PWDATA_IN[IRQ_WIDTH-1:0];
                default: ;
            endcase
        end
    end

    // Overtemperature latches a shutdown that only a reset clears.
    always_ff @(posedge CLK_SYS_IN or negedge rst_n)
    begin
        if (!rst_n)
            shutdown_r <= 1'b0;
        else if (overtemp_level)
            shutdown_r <= 1'b1; // [RULE_08]
    end

    // Capture engine: records run for RECORD_CYCLES, streaming adds a ready gap.
    always_ff @(posedge CLK_SYS_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= ST_IDLE;
            cnt_r <= '0;
        end
        else if (shutdown_r || cmd_escape)
        begin
            state_r <= ST_IDLE; // [RULE_06] [RULE_08]
            cnt_r <= '0;
        end
        else
        begin
            unique case (state_r)
                ST_IDLE:
                begin
                    cnt_r <= '0;
                    if (!loading && (cmd_capture || (!continuous && trig_rise)))
                        state_r <= ST_RECORD; // [RULE_02]
                    else if (!loading && continuous && trig_en && trig_level)
                        state_r <= ST_RECORD; // [RULE_03]
                end
                ST_RECORD:
                begin
                    cnt_r <= cnt_r + 16'h0001;
                    if (record_done)
                    begin
                        cnt_r <= '0;
                        // A low trigger only stops after the current record.
                        if (!(continuous && trig_en && trig_level))
                            state_r <= ST_IDLE; // [RULE_03]
                        else if (mode_r == MODE_STREAMING)
                            state_r <= ST_READY_GAP; // [RULE_04]
                    end
                end
                ST_READY_GAP:
                begin
                    cnt_r <= cnt_r + 16'h0001;
                    if (gap_done)
                    begin
                        cnt_r <= '0;
                        state_r <= (trig_en && trig_level) ? ST_RECORD : ST_IDLE;
                    end
                end
                default:
                begin
                    state_r <= ST_IDLE;
                    cnt_r <= '0;
                end
            endcase
        end
    end

    // Busy pin: data-ready in streaming, otherwise low while any work runs.
    always_ff @(posedge CLK_SYS_IN or negedge rst_n)
    begin
        if (!rst_n)
            busy_r <= 1'b0;
        else if (mode_r == MODE_STREAMING)
            busy_r <= !loading && state_r != ST_RECORD; // [RULE_04]
        else
            busy_r <= !loading && state_r == ST_IDLE; // [RULE_05] [RULE_10]
    end
    assign BUSY_OUT = busy_r;

    // Alarm pins: enable and polarity per pin, held inactive in streaming.
    always_ff @(posedge CLK_SYS_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ALARM_OUT_FIRST_OUT <= 1'b0;
            ALARM_OUT_SECOND_OUT <= 1'b0;
        end
        else
        begin
            ALARM_OUT_FIRST_OUT <= alarm_ctrl_r[ALARM_POLARITY_LSB] ^
                (alarm_ctrl_r[ALARM_ENABLE_LSB] && ALARM_EVENT_IN[0]
                 && mode_r != MODE_STREAMING); // [RULE_07]
            ALARM_OUT_SECOND_OUT <= alarm_ctrl_r[ALARM_POLARITY_LSB + 1] ^
                (alarm_ctrl_r[ALARM_ENABLE_LSB + 1] && ALARM_EVENT_IN[1]
                 && mode_r != MODE_STREAMING); // [RULE_07]
        end
    end

    // Supply monitor pin idles high and drops on shutdown.
    always_ff @(posedge CLK_SYS_IN or negedge rst_n)
    begin
        if (!rst_n)
            SUPPLY_MONITOR_OUT <= 1'b1;
        else
            SUPPLY_MONITOR_OUT <= !shutdown_r; // [RULE_08]
    end

    // Sticky events; a set in the same cycle as a write-one clear wins.
    always_comb
    begin
        irq_set = '0;
        irq_set[IRQ_RECORD_DONE] = record_done && !shutdown_r && !cmd_escape;
        irq_set[IRQ_TRIGGER] = trig_rise;
        irq_set[IRQ_OVERTEMP] = overtemp_level && !shutdown_r;
        irq_set[IRQ_ESCAPE] = cmd_escape && state_r != ST_IDLE;
    end

    always_ff @(posedge CLK_SYS_IN or negedge rst_n)
    begin
        if (!rst_n)
            irq_status_r <= '0;
        else if (wr_ok && PADDR_IN == IRQ_STATUS_OFFSET)
            irq_status_r <= (irq_status_r & ~PWDATA_IN[IRQ_WIDTH-1:0]) | irq_set;
        else
            irq_status_r <= irq_status_r | irq_set;
    end
    assign IRQ_OUT = |(irq_status_r & irq_mask_r);

    // Read data is registered so the bus sees it in the access phase.
    always_ff @(posedge CLK_SYS_IN or negedge rst_n)
    begin
        if (!rst_n)
            PRDATA_OUT <= '0;
        else if (PSEL_IN && !PENABLE_IN && !PWRITE_IN)
        begin
            PRDATA_OUT <= '0;
            unique case (PADDR_IN)
                MISC_CONTROL_OFFSET: PRDATA_OUT <= {16'h0000, misc_ctrl_r};
                MODE_OFFSET: PRDATA_OUT <= {30'h0, mode_r};
                ALARM_CONTROL_OFFSET: PRDATA_OUT <= {28'h0000000, alarm_ctrl_r};
                STATUS_OFFSET:
                begin
                    PRDATA_OUT[STATUS_BUSY_BIT] <= !busy_r;
                    PRDATA_OUT[STATUS_ACTIVE_BIT] <= state_r != ST_IDLE;
                    PRDATA_OUT[STATUS_SHUTDOWN_BIT] <= shutdown_r;
                    PRDATA_OUT[STATUS_LOADING_BIT] <= loading;
                    PRDATA_OUT[STATUS_MODE_LSB +: 2] <= mode_r;
                end
                IRQ_STATUS_OFFSET: PRDATA_OUT[IRQ_WIDTH-1:0] <= irq_status_r;
                IRQ_MASK_OFFSET: PRDATA_OUT[IRQ_WIDTH-1:0] <= irq_mask_r;
                default: ;
            endcase
        end
    end

endmodule : vibration_sensor_host_pins

// [testbench/host_trig_model.sv]
`timescale 1ns/1ps
module host_trig_model
    import vib_pins_pkg::*;
(
    // Clock and the level the host asks for.
    input wire logic clk_in,
    input wire logic level_in,
    // Trigger pin.
    output logic trigger_out
);
    int hold_r = 0;

    // Stretch each request, since a pulse shorter than the minimum may be missed.
    always @(posedge clk_in)
    begin
        if (level_in)
            hold_r <= TRIG_MIN_PULSE_CYCLES;
        else if (hold_r > 0)
            hold_r <= hold_r - 1;
        trigger_out <= level_in || hold_r > 1;
    end
endmodule : host_trig_model

// [testbench/vib_pins_sva.sv]
`timescale 1ns/1ps
module vib_pins_sva
    import vib_pins_pkg::*;
#(
    parameter int RECORD_CYCLES = 4096,
    parameter int READY_GAP_CYCLES = 64,
    parameter int FLASH_LOAD_CYCLES = 16
)
(
    // Clock and reset.
    input wire logic CLK_SYS_IN,
    input wire logic NRST_IN,
    // Bus.
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic PREADY_OUT,
    input wire logic PSLVERR_OUT,
    // Pins and sources.
    input wire logic TRIGGER_IN,
    input wire logic OVERTEMP_IN,
    input wire logic BUSY_OUT,
    input wire logic ALARM_OUT_FIRST_OUT,
    input wire logic ALARM_OUT_SECOND_OUT,
    input wire logic SUPPLY_MONITOR_OUT,
    input wire logic [1:0] ALARM_EVENT_IN,
    input wire logic [31:0] FLASH_WORD_IN,
    input wire logic IRQ_OUT
);
    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (!NRST_IN);

    // Decoded write accesses; BUSY_OUT high in the quiet terms keeps the reload out.
    wire logic wr_acc = PSEL_IN && PENABLE_IN && PWRITE_IN;
    wire logic cmd_acc = wr_acc && PADDR_IN == GLOBAL_COMMAND_OFFSET;
    wire logic esc_acc = cmd_acc && PWDATA_IN[15:0] == CMD_ESCAPE;
    wire logic cap_acc = cmd_acc && PWDATA_IN[15:0] == CMD_CAPTURE;
    wire logic quiet1 = !ALARM_EVENT_IN[0] && !(PSEL_IN && PWRITE_IN) && BUSY_OUT;
    wire logic quiet2 = !ALARM_EVENT_IN[1] && !(PSEL_IN && PWRITE_IN) && BUSY_OUT;

    AST_RESET_OUTS:
        assert property (disable iff (1'b0) !NRST_IN [*2] |-> !BUSY_OUT && SUPPLY_MONITOR_OUT
            && !IRQ_OUT) else $error("Outputs off their reset values");
    AST_RELOAD_BUSY:
        assert property ($rose(NRST_IN) |-> !BUSY_OUT [*4]) else $error("Busy high in reload");
    AST_SHUTDOWN:
        assert property (OVERTEMP_IN [*6] |-> ##[0:4] !SUPPLY_MONITOR_OUT)
        else $error("No shutdown on overtemperature");
    AST_SHUT_HOLD:
        assert property (!SUPPLY_MONITOR_OUT |=> !SUPPLY_MONITOR_OUT) else $error("Shutdown lost");
    AST_ALARM_FIRST:
        assert property (quiet1 [*2] |=> $stable(ALARM_OUT_FIRST_OUT)) else $error("Alarm 1 moved");
    AST_ALARM_SECOND:
        assert property (quiet2 [*2] |=> $stable(ALARM_OUT_SECOND_OUT)) else $error("Alarm 2 moved");
    AST_CAPTURE_BUSY:
        assert property (cap_acc && BUSY_OUT && SUPPLY_MONITOR_OUT && !PSLVERR_OUT
            |-> ##[1:3] !BUSY_OUT) else $error("Capture did not raise busy");
    AST_ESCAPE_TAKEN:
        assert property (esc_acc |-> !PSLVERR_OUT) else $error("Escape refused");
    AST_ESCAPE_ENDS:
        assert property (esc_acc && !BUSY_OUT && SUPPLY_MONITOR_OUT |-> ##[1:4] BUSY_OUT)
        else $error("Escape did not end capture");
    AST_REFUSE_PHASE:
        assert property (PSLVERR_OUT |-> PSEL_IN && PENABLE_IN) else $error("Stray error");

    // Main scenarios reached.
    cover property (esc_acc && !BUSY_OUT);
    cover property (cap_acc && BUSY_OUT);
    cover property ($fell(SUPPLY_MONITOR_OUT));
endmodule : vib_pins_sva

// [testbench/tb.sv]
`timescale 1ns/1ps
module tb
    import vib_pins_pkg::*;
;
    logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, trig_req = 1'b0;
    logic ovt = 1'b0, err, trig, pready, pslverr, busy, al1, al2, supmon, irq;
    logic [1:0] alev = 2'b00;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, flash = 32'h0, rdata, prdata;
    int fail_count = 0, total_checks = 0, cyc, i;

    // System clock.
    always #20 clk = ~clk;

    // Short record, gap and reload counts keep the run brief.
    vibration_sensor_host_pins #(.RECORD_CYCLES(16), .READY_GAP_CYCLES(4), .FLASH_LOAD_CYCLES(4))
    uut (.CLK_SYS_IN(clk), .NRST_IN(nrst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
        .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .TRIGGER_IN(trig), .OVERTEMP_IN(ovt), .BUSY_OUT(busy),
        .ALARM_OUT_FIRST_OUT(al1), .ALARM_OUT_SECOND_OUT(al2), .SUPPLY_MONITOR_OUT(supmon),
        .ALARM_EVENT_IN(alev), .FLASH_WORD_IN(flash), .IRQ_OUT(irq));
    host_trig_model partner (.clk_in(clk), .level_in(trig_req), .trigger_out(trig));

    task end_sim;
        $display("Checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_sim

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    // One step of a bounded wait; running out ends the run.
    task tick(input int max);
        cyc++;
        if (cyc > max)
        begin
            fail_count++;
            $display("Error at %0t: wait ran out", $time);
            end_sim;
        end
        @(negedge clk);
    endtask : tick

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        cyc = 0;
        @(posedge clk);
        while (pready !== 1'b1)
        begin
            tick(20);
            @(posedge clk);
        end
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb

    task wait_busy(input logic lvl, input int max);
        cyc = 0;
        while (busy !== lvl)
            tick(max);
    endtask : wait_busy

    task stay(input int n, input logic lvl);
        for (i = 0; i < n; i++)
        begin
            @(negedge clk);
            if (busy !== lvl)
                break;
        end
        chk(i, n);
    endtask : stay

    task pins(input logic t, input logic [1:0] a, input logic o);
        @(posedge clk);
        trig_req <= t;
        alev <= a;
        ovt <= o;
    endtask : pins

    task t_reload(input logic [31:0] word);
        @(posedge clk);
        nrst <= 1'b0;
        flash <= word;
        repeat (16) @(posedge clk);
        chk({busy, supmon, irq}, 3'b010);
        nrst <= 1'b1;
        wait_busy(1'b1, 40);
        chk(32'(cyc > 4), 1);
        apb(1'b0, MODE_OFFSET, 32'h0);
        chk(rdata, 32'(word[1:0]));
        apb(1'b0, ALARM_CONTROL_OFFSET, 32'h0);
        chk(rdata, 32'(word[19:16]));
        apb(1'b0, MISC_CONTROL_OFFSET, 32'h0);
        chk(rdata[TRIG_ENABLE_BIT], word[12]);
        chk({al2, al1}, 32'(word[19:18]));
    endtask : t_reload

    task t_capture;
        apb(1'b1, IRQ_MASK_OFFSET, 32'h1);
        apb(1'b1, GLOBAL_COMMAND_OFFSET, 32'(CMD_CAPTURE));
        wait_busy(1'b0, 3);
        apb(1'b1, MISC_CONTROL_OFFSET, 32'h0);
        chk(err, 1'b1);
        wait_busy(1'b1, 20);
        chk(32'(cyc > 8), 1);
        chk(irq, 1'b1);
        apb(1'b1, IRQ_STATUS_OFFSET, 32'h1);
        @(negedge clk);
        chk(irq, 1'b0);
        apb(1'b1, MISC_CONTROL_OFFSET, 32'h1000);
        chk(err, 1'b0);
    endtask : t_capture

    task t_escape;
        apb(1'b1, GLOBAL_COMMAND_OFFSET, 32'(CMD_CAPTURE));
        wait_busy(1'b0, 3);
        apb(1'b1, GLOBAL_COMMAND_OFFSET, 32'(CMD_ESCAPE));
        chk(err, 1'b0);
        wait_busy(1'b1, 4);
        apb(1'b0, IRQ_STATUS_OFFSET, 32'h0);
        chk(rdata[IRQ_ESCAPE], 1'b1);
        apb(1'b1, IRQ_STATUS_OFFSET, 32'hF);
    endtask : t_escape

    // Both manual modes: a disabled pin is ignored, an enabled edge starts one record.
    task t_trigger;
        for (int m = 0; m < 2; m++)
        begin
            apb(1'b1, MODE_OFFSET, 32'(m));
            apb(1'b1, MISC_CONTROL_OFFSET, 32'h0);
            pins(1'b1, 2'b00, 1'b0);
            pins(1'b0, 2'b00, 1'b0);
            stay(12, 1'b1);
            apb(1'b0, IRQ_STATUS_OFFSET, 32'h0);
            chk(rdata[IRQ_TRIGGER], 1'b0);
            apb(1'b1, MISC_CONTROL_OFFSET, 32'h1000);
            pins(1'b1, 2'b00, 1'b0);
            pins(1'b0, 2'b00, 1'b0);
            wait_busy(1'b0, 10);
            wait_busy(1'b1, 25);
            apb(1'b0, IRQ_STATUS_OFFSET, 32'h0);
            chk(rdata[IRQ_TRIGGER], 1'b1);
            apb(1'b1, IRQ_STATUS_OFFSET, 32'hF);
        end
    endtask : t_trigger

    task t_stream;
        apb(1'b1, ALARM_CONTROL_OFFSET, 32'h3);
        apb(1'b1, MODE_OFFSET, 32'(MODE_STREAMING));
        pins(1'b1, 2'b11, 1'b0);
        wait_busy(1'b0, 10);
        chk({al2, al1}, 2'b00);
        wait_busy(1'b1, 20);
        wait_busy(1'b0, 8);
        pins(1'b0, 2'b11, 1'b0);
        wait_busy(1'b1, 20);
        stay(20, 1'b1);
        apb(1'b1, MODE_OFFSET, 32'(MODE_AUTO_SPECTRAL));
        repeat (2) @(negedge clk);
        chk({al2, al1}, 2'b11);
        pins(1'b1, 2'b01, 1'b0);
        wait_busy(1'b0, 10);
        pins(1'b0, 2'b01, 1'b0);
        wait_busy(1'b1, 25);
        chk(32'(cyc > 8), 1);
        chk({al2, al1}, 2'b01);
    endtask : t_stream

    task t_overtemp;
        pins(1'b0, 2'b00, 1'b1);
        cyc = 0;
        while (supmon !== 1'b0)
            tick(10);
        pins(1'b0, 2'b00, 1'b0);
        repeat (8) @(negedge clk);
        chk(supmon, 1'b0);
        apb(1'b0, IRQ_STATUS_OFFSET, 32'h0);
        chk(rdata[IRQ_OVERTEMP], 1'b1);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        chk(rdata, 32'h0000_0024);
    endtask : t_overtemp

    // Main sequence; the second reset also clears the latched shutdown.
    initial
    begin
        t_reload(32'h0005_1000);
        t_capture;
        t_escape;
        t_trigger;
        t_stream;
        t_overtemp;
        t_reload(32'h000A_0003);
        chk(supmon, 1'b1);
        end_sim;
    end
endmodule : tb

bind vibration_sensor_host_pins vib_pins_sva #(.RECORD_CYCLES(RECORD_CYCLES),
    .READY_GAP_CYCLES(READY_GAP_CYCLES), .FLASH_LOAD_CYCLES(FLASH_LOAD_CYCLES))
u_sva (.CLK_SYS_IN(CLK_SYS_IN), .NRST_IN(NRST_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
    .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT),
    .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .TRIGGER_IN(TRIGGER_IN),
    .OVERTEMP_IN(OVERTEMP_IN), .BUSY_OUT(BUSY_OUT), .ALARM_OUT_FIRST_OUT(ALARM_OUT_FIRST_OUT),
    .ALARM_OUT_SECOND_OUT(ALARM_OUT_SECOND_OUT), .SUPPLY_MONITOR_OUT(SUPPLY_MONITOR_OUT),
    .ALARM_EVENT_IN(ALARM_EVENT_IN), .FLASH_WORD_IN(FLASH_WORD_IN), .IRQ_OUT(IRQ_OUT));
